// ==== src/dcc_pkg.sv ====
// Constants, field layout and carrier types of the dual comparator control block
package dcc_pkg;
  localparam int DCC_AW = 3;
  localparam int DCC_DW = 8;

  // Register offsets
  localparam logic [2:0] DCC_CTRL_OFS = 3'h0;
  localparam logic [2:0] DCC_IRQ_OFS  = 3'h1;
  localparam logic [2:0] DCC_DIR_OFS  = 3'h2;
  localparam logic [2:0] DCC_LAT_OFS  = 3'h3;
  localparam logic [2:0] DCC_PORT_OFS = 3'h4;

  // comparator_control fields
  localparam int DCC_C2_RES_BIT = 7;
  localparam int DCC_C1_RES_BIT = 6;
  localparam int DCC_C2_INV_BIT = 5;
  localparam int DCC_C1_INV_BIT = 4;
  localparam int DCC_CIS_BIT    = 3;
  localparam int DCC_MODE_MSB   = 2;
  localparam int DCC_CFG_MSB    = 5;

  // Interrupt register fields
  localparam int DCC_FLAG_BIT = 0;
  localparam int DCC_EN_BIT   = 1;
  localparam int DCC_PRI_BIT  = 2;
  localparam int DCC_PERIPHERAL_INTERRUPT_ENABLE_BIT = 3;
  localparam int DCC_GIE_BIT  = 4;
  localparam int DCC_IRQ_MSB  = 4;

  // Reset values
  localparam logic [7:0] DCC_CTRL_RST = 8'h00;
  localparam logic [4:0] DCC_IRQ_RST  = 5'h00;
  localparam logic [7:0] DCC_DIR_RST  = 8'hff;
  localparam logic [7:0] DCC_LAT_RST  = 8'h00;
  localparam logic [1:0] DCC_SYNC_RST = 2'h0;

  // Port F pins used by the comparators
  localparam int DCC_PIN_RES1 = 1;
  localparam int DCC_PIN_RES2 = 2;

  // Mode codes
  localparam logic [2:0] DCC_MODE_RESET   = 3'h0;
  localparam logic [2:0] DCC_MODE_ONE     = 3'h1;
  localparam logic [2:0] DCC_MODE_TWO     = 3'h2;
  localparam logic [2:0] DCC_MODE_COMMON  = 3'h3;
  localparam logic [2:0] DCC_MODE_TWO_OUT = 3'h4;
  localparam logic [2:0] DCC_MODE_COM_OUT = 3'h5;
  localparam logic [2:0] DCC_MODE_VREF    = 3'h6;
  localparam logic [2:0] DCC_MODE_OFF     = 3'h7;

  // Analog pin masks per mode
  localparam logic [7:0] DCC_MASK_ALL    = 8'h7e;
  localparam logic [7:0] DCC_MASK_ONE    = 8'h60;
  localparam logic [7:0] DCC_MASK_TWO    = 8'h78;
  localparam logic [7:0] DCC_MASK_COMMON = 8'h70;
  localparam logic [7:0] DCC_MASK_NONE   = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } dcc_bus_req_t;

  typedef struct packed {
    logic       c1_on;
    logic       c2_on;
    logic       vref_plus;
    logic       c1_sel_alt_a;
    logic       c2_sel_alt_c;
    logic       pins_out;
    logic [7:0] analog_mask;
  } dcc_cfg_t;
endpackage : dcc_pkg

// ==== src/dcc_top.sv ====
// Dual comparator control: mode register, result readback, mismatch flag, port mux
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire dcc_pkg::dcc_bus_req_t bus_in,
  output logic [dcc_pkg::DCC_DW-1:0] rdata_out,
  input  wire logic                 comp1_raw_in,
  input  wire logic                 comp2_raw_in,
  output dcc_pkg::dcc_cfg_t          cfg_out,
  input  wire logic [7:0]           port_pin_in,
  output logic [7:0]                port_pin_out,
  output logic [7:0]                port_pin_oe_out,
  output logic                      irq_out,
  output logic                      irq_priority_out,
  output logic                      wake_out
);
  import dcc_pkg::*;

  logic [7:0]         ctrl_reg;
  logic [DCC_IRQ_MSB:0] irq_reg;
  logic [DCC_IRQ_MSB:0] irq_next;
  logic [7:0]         dir_reg;
  logic [7:0]         lat_reg;
  logic [1:0]         sync1_reg;
  logic [1:0]         sync2_reg;
  logic [1:0]         capt_reg;
  logic [1:0]         result;
  logic [1:0]         raw_pol;
  logic               ctrl_access;
  logic               mismatch;
  logic [7:0]         port_read;
  dcc_cfg_t           cfg_now;
  dcc_cfg_t           cfg_reg;

  // Mode decode table
  function automatic dcc_cfg_t mode_cfg(input logic [2:0] mode, input logic input_switch_select);
    dcc_cfg_t c;
    c = '0;
    case (mode)
      DCC_MODE_RESET: begin
        c.analog_mask = DCC_MASK_ALL;
      end
      DCC_MODE_ONE: begin
        c.c1_on       = 1'b1;
        c.analog_mask = DCC_MASK_ONE;
      end
      DCC_MODE_TWO: begin
        c.c1_on       = 1'b1;
        c.c2_on       = 1'b1;
        c.analog_mask = DCC_MASK_TWO;
      end
      DCC_MODE_COMMON: begin
        c.c1_on       = 1'b1;
        c.c2_on       = 1'b1;
        c.analog_mask = DCC_MASK_COMMON;
      end
      DCC_MODE_TWO_OUT: begin
        c.c1_on       = 1'b1;
        c.c2_on       = 1'b1;
        c.pins_out    = 1'b1;
        c.analog_mask = DCC_MASK_TWO;
      end
      DCC_MODE_COM_OUT: begin
        c.c1_on       = 1'b1;
        c.c2_on       = 1'b1;
        c.pins_out    = 1'b1;
        c.analog_mask = DCC_MASK_COMMON;
      end
      DCC_MODE_VREF: begin
        c.c1_on        = 1'b1;
        c.c2_on        = 1'b1;
        c.vref_plus    = 1'b1;
        c.c1_sel_alt_a = input_switch_select;
        c.c2_sel_alt_c = input_switch_select;
        c.analog_mask  = DCC_MASK_TWO;
      end
      DCC_MODE_OFF: begin
        c.analog_mask = DCC_MASK_NONE;
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction : mode_cfg

  assign cfg_now = mode_cfg(ctrl_reg[DCC_MODE_MSB:0], ctrl_reg[DCC_CIS_BIT]);

  // Register the analog configuration; cleared while reset holds
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_now;
    end
  end
  assign cfg_out = cfg_reg;

  // Control register; result bits never stored
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= DCC_CTRL_RST;
    end else if (bus_in.wr && bus_in.addr == DCC_CTRL_OFS) begin
      ctrl_reg[DCC_CFG_MSB:0] <= bus_in.wdata[DCC_CFG_MSB:0];
    end
  end
  // Upper bits unused as storage
  assign ctrl_access = (bus_in.wr | bus_in.rd) && bus_in.addr == DCC_CTRL_OFS;

  // Polarity applied to the raw outputs, gated by comparator power
  assign raw_pol[0] = cfg_reg.c1_on & (comp1_raw_in ^ ctrl_reg[DCC_C1_INV_BIT]);
  assign raw_pol[1] = cfg_reg.c2_on & (comp2_raw_in ^ ctrl_reg[DCC_C2_INV_BIT]);

  // Two-stage synchroniser on the raw comparator outputs
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= DCC_SYNC_RST;
      sync2_reg <= DCC_SYNC_RST;
    end else begin
      sync1_reg <= {comp2_raw_in, comp1_raw_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign result[0] = cfg_reg.c1_on & (sync2_reg[0] ^ ctrl_reg[DCC_C1_INV_BIT]);
  assign result[1] = cfg_reg.c2_on & (sync2_reg[1] ^ ctrl_reg[DCC_C2_INV_BIT]);

  // Captured results, refreshed by every control register access
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      capt_reg <= DCC_SYNC_RST;
    end else if (ctrl_access) begin
      capt_reg <= result;
    end
  end

  // Same-cycle change and access still flags (allowed to miss, we do not)
  assign mismatch = result != capt_reg;

  // Interrupt flag and enables; hardware set wins over software clear
  always_comb begin
    irq_next = irq_reg;
    if (bus_in.wr && bus_in.addr == DCC_IRQ_OFS) begin
      irq_next = bus_in.wdata[DCC_IRQ_MSB:0];
    end
    if (mismatch) begin
      irq_next[DCC_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_reg <= DCC_IRQ_RST;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Core request needs all enables; wake needs only the block enable
  assign irq_out = irq_reg[DCC_FLAG_BIT] & irq_reg[DCC_EN_BIT] &
                   irq_reg[DCC_PERIPHERAL_INTERRUPT_ENABLE_BIT] & irq_reg[DCC_GIE_BIT];
  assign wake_out = irq_reg[DCC_FLAG_BIT] & irq_reg[DCC_EN_BIT];
  assign irq_priority_out = irq_reg[DCC_PRI_BIT];

  // Port direction and latch
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      dir_reg <= DCC_DIR_RST;
    end else if (bus_in.wr && bus_in.addr == DCC_DIR_OFS) begin
      dir_reg <= bus_in.wdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lat_reg <= DCC_LAT_RST;
    end else if (bus_in.wr && bus_in.addr == DCC_LAT_OFS) begin
      lat_reg <= bus_in.wdata;
    end
  end

  // Pin drive: raw results bypass the latch in output modes
  always_comb begin
    port_pin_out = lat_reg;
    if (cfg_reg.pins_out) begin
      port_pin_out[DCC_PIN_RES1] = raw_pol[0];
      port_pin_out[DCC_PIN_RES2] = raw_pol[1];
    end
  end
  assign port_pin_oe_out = ~dir_reg;

  assign port_read = port_pin_in & ~cfg_reg.analog_mask;

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        DCC_CTRL_OFS: rdata_out <= {result[1], result[0], ctrl_reg[DCC_CFG_MSB:0]};
        DCC_IRQ_OFS:  rdata_out <= {3'h0, irq_reg};
        DCC_DIR_OFS:  rdata_out <= dir_reg;
        DCC_LAT_OFS:  rdata_out <= lat_reg;
        DCC_PORT_OFS: rdata_out <= port_read;
        default:      rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end
endmodule : dcc_top

// ==== test/dcc_sva.sv ====
// Port assertions for the comparator control block
`timescale 1ns/1ps
module dcc_sva
  import dcc_pkg::*;
(
  input wire logic         mclk_in,
  input wire logic         rst_n_in,
  input wire dcc_bus_req_t bus_in,
  input wire logic [7:0]   rdata_out,
  input wire logic         comp1_raw_in,
  input wire dcc_cfg_t     cfg_out,
  input wire logic [7:0]   port_pin_out,
  input wire logic [7:0]   port_pin_oe_out,
  input wire logic         irq_out,
  input wire logic         wake_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ctrl_wr;
    bus_in.wr && bus_in.addr == DCC_CTRL_OFS;
  endsequence
  function automatic logic [11:0] exp_cfg(input logic [2:0] m);
    logic [7:0] k;
    k = m == 3'h0 ? DCC_MASK_ALL : m == 3'h1 ? DCC_MASK_ONE : m == 3'h7 ? DCC_MASK_NONE :
        m[0] ? DCC_MASK_COMMON : DCC_MASK_TWO;
    return {m != 3'h0 && m != 3'h7, m > 3'h1 && m != 3'h7, m == 3'h6, m[2] & ~m[1], k};
  endfunction : exp_cfg
  AST_RD_IDLE: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  AST_RST_CFG: assert property (!$past(rst_n_in) |-> cfg_out == '0)
    else $error("config not cleared");
  AST_MODE_CFG: assert property (s_ctrl_wr |-> ##2 {cfg_out[13:11], cfg_out[8:0]} ==
    exp_cfg($past(bus_in.wdata[2:0], 2))) else $error("mode config wrong");
  AST_SWITCH: assert property (s_ctrl_wr ##0 bus_in.wdata[2:0] == 3'h6 |-> ##2
    cfg_out[10:9] == {2{$past(bus_in.wdata[3], 2)}}) else $error("input switch wrong");
  AST_DIR_OE: assert property (bus_in.wr && bus_in.addr == DCC_DIR_OFS |=>
    port_pin_oe_out == ~$past(bus_in.wdata)) else $error("pin enable wrong");
  AST_PIN_RAW: assert property (cfg_out.pins_out && cfg_out.c1_on && $stable(cfg_out) &&
    !$past(bus_in.wr) |-> $changed(port_pin_out[1]) == $changed(comp1_raw_in))
    else $error("pin not raw result");
  AST_IRQ_GATE: assert property (irq_out |-> wake_out) else $error("irq gate");
  AST_SW_SET: assert property (bus_in.wr && bus_in.addr == DCC_IRQ_OFS &&
    bus_in.wdata[1:0] == 2'h3 |=> wake_out) else $error("software set lost");
endmodule : dcc_sva

bind dcc_top dcc_sva u_sva (.mclk_in, .rst_n_in, .bus_in, .rdata_out, .comp1_raw_in, .cfg_out,
  .port_pin_out, .port_pin_oe_out, .irq_out, .wake_out);

// ==== test/dcc_analog_model.sv ====
// Analog side: comparator decisions and resolved port pin levels
`timescale 1ns/1ps
module dcc_analog_model (
  input  wire logic       mclk_in,
  input  wire logic [1:0] above_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] ext_in,
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] pin_oe_in,
  output logic            comp1_out,
  output logic            comp2_out,
  output logic [7:0]      pin_level_out
);
  logic [7:0] settle_reg = 8'h00;
  always @(posedge mclk_in) begin
    settle_reg <= {settle_reg[5:0], above_in};
  end
  // Slow inputs settle four cycles late
  assign {comp2_out, comp1_out} = slow_in ? settle_reg[7:6] : above_in;
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_in);
endmodule : dcc_analog_model

// ==== test/dcc_top_test.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module dcc_top_test;
  import dcc_pkg::*;
  logic         mclk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  dcc_bus_req_t bus = '0;
  logic [7:0]   rdata, lvl, pout, oe, w, d, e;
  logic [7:0]   ext = 8'h00;
  logic [1:0]   above = 2'h0;
  logic [1:0]   c;
  logic         slow = 1'b0;
  logic         c1, c2, irq, pri, wake;
  int           error_cnt = 0;
  int           checks = 0;
  integer       seed = 71;

  always #2.5 mclk_in = ~mclk_in;

  dcc_top u_dut (.mclk_in, .rst_n_in, .bus_in(bus), .rdata_out(rdata), .comp1_raw_in(c1),
    .comp2_raw_in(c2), .cfg_out(), .port_pin_in(lvl), .port_pin_out(pout),
    .port_pin_oe_out(oe), .irq_out(irq), .irq_priority_out(pri), .wake_out(wake));
  dcc_analog_model u_ana (.mclk_in, .above_in(above), .slow_in(slow), .ext_in(ext),
    .pin_out_in(pout), .pin_oe_in(oe), .comp1_out(c1), .comp2_out(c2), .pin_level_out(lvl));

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge mclk_in);
    bus <= '0;
    @(posedge mclk_in);
  endtask : wr

  task automatic rd(input logic [2:0] a);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_in);
    bus <= '0;
    #1 d = rdata;
    @(posedge mclk_in);
  endtask : rd

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Off comparators read 0 whatever the inversion
  function automatic logic [7:0] exp_ctrl(input logic [7:0] v, input logic [1:0] k);
    logic on1;
    on1 = v[2:0] != 3'h0 && v[2:0] != 3'h7;
    return {on1 && v[2:0] != 3'h1 && (k[1] ^ v[5]), on1 && (k[0] ^ v[4]), v[5:0]};
  endfunction : exp_ctrl

  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    ext <= 8'($random(seed));
    rd(DCC_CTRL_OFS); chk("ctrl reset", DCC_CTRL_RST, d);
    rd(DCC_DIR_OFS); chk("dir reset", DCC_DIR_RST, d);
    wr(3'h5, 8'hff);
    rd(3'h5); chk("unmapped", 8'h00, d);
    rd(DCC_PORT_OFS); chk("port analog", ext & ~DCC_MASK_ALL, d);
    $display("test reset done");
    wr(DCC_DIR_OFS, 8'hf9);
    wr(DCC_LAT_OFS, 8'h00);
    for (int i = 0; i < 24; i++) begin
      w = 8'($random(seed));
      c = 2'($random(seed));
      if (i < 8) w[2:0] = i[2:0];
      above <= c;
      slow <= w[7];
      wr(DCC_CTRL_OFS, w);
      repeat (8) @(posedge mclk_in);
      e = exp_ctrl(w, c);
      rd(DCC_CTRL_OFS); chk("ctrl", e, d);
      if (w[2:1] == 2'h2) begin
        chk("pins", {6'h00, e[7:6]}, {6'h00, pout[2:1]});
        chk("pin enable", 8'h06, oe);
      end
    end
    $display("test modes done");
    slow <= 1'b1;
    above <= 2'h0;
    wr(DCC_CTRL_OFS, 8'h02);
    repeat (8) @(posedge mclk_in);
    rd(DCC_CTRL_OFS);
    wr(DCC_IRQ_OFS, 8'h02);
    rd(DCC_IRQ_OFS); chk("flag clear", 8'h02, d);
    above <= 2'h1;
    repeat (10) @(posedge mclk_in);
    rd(DCC_IRQ_OFS); chk("flag set", 8'h03, d);
    chk("wake", 8'h01, {7'h00, wake});
    wr(DCC_IRQ_OFS, 8'h02);
    rd(DCC_IRQ_OFS); chk("flag held", 8'h03, d);
    rd(DCC_CTRL_OFS); chk("ctrl kept", exp_ctrl(8'h02, 2'h1), d);
    wr(DCC_IRQ_OFS, 8'h02);
    rd(DCC_IRQ_OFS); chk("flag end", 8'h02, d);
    wr(DCC_IRQ_OFS, 8'h1f); chk("irq all", 8'h03, {6'h00, pri, irq});
    wr(DCC_IRQ_OFS, 8'h0f); chk("irq gated", 8'h02, {6'h00, wake, irq});
    $display("test flag done");
    conclude();
  end

  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule : dcc_top_test
